// ---- hdl/ifdd_pkg.sv ----
// Purpose: Shared constants for the IF downconverter and decimator.
// Assumes: Samples are two's complement; zero code is 0.
// Notes: The decimation count sets the baseband sample strobe period.
// Function
// - Direct mode uses only two mixer multipliers.
// - Quadrature mode uses all four multipliers.
// - Oscillator gives complex tone at minus IF.
// - Integrate N inputs, emit one output.
// - Set N for two samples per chip.
// - Six-bit count, programmable 2 to 64.
package ifdd_pkg;
   localparam int SAMPLE_W = 8;
   localparam int NCO_W = 8;
   localparam int PHASE_W = 32;
   localparam int ACC_W = 24;
   localparam int DEC_FIELD_W = 6;
   localparam int DEC_MIN = 2;
   localparam int DEC_MAX = 64;
   localparam int FIFO_DEPTH = 4;
   localparam logic [DEC_FIELD_W-1:0] DEC_RESET = 6'h02;
   localparam logic PHASE_LUT_BITS = 1'b0;
   typedef enum logic {IFDD_MODE_DIRECT, IFDD_MODE_QUAD} ifdd_mode_t;
endpackage

// ---- hdl/ifdd_fifo.sv ----
// Purpose: Small valid/ready FIFO for baseband samples.
// Assumes: One clock, synchronous reset copy.
// Notes: Full and empty are exact; output data is read combinationally from memory at the read pointer.
`timescale 1ns/1ps
`default_nettype none
module ifdd_fifo #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } ifdd_fifo_st_t;
   ifdd_fifo_st_t s_q, s_d;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic push, pop;
   assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s_q.cnt != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_q[s_q.rp];
   always_comb begin
      s_d = s_q;
      if (push) s_d.wp = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + 1'b1;
      if (pop) s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + 1'b1;
      if (push && !pop) s_d.cnt = s_q.cnt + 1'b1;
      else if (pop && !push) s_d.cnt = s_q.cnt - 1'b1;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) s_q <= '0;
      else s_q <= s_d;
   end
   always_ff @(posedge clk) begin
      if (push) mem_q[s_q.wp] <= in_data;
   end
endmodule // ifdd_fifo
`default_nettype wire

// ---- hdl/ifdd_top.sv ----
// Purpose: IF downconverter with complex mixer and integrate-and-dump decimator.
// Assumes: mclk is the IF sample clock; one sample per cycle.
// Notes: Outputs pass a four-word FIFO; a stalled sink stalls the input.
`timescale 1ns/1ps
`default_nettype none
module ifdd_top
   import ifdd_pkg::*;
#(
   parameter int SAMPLE_W = ifdd_pkg::SAMPLE_W,
   parameter int ACC_W = ifdd_pkg::ACC_W
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire ifdd_pkg::ifdd_mode_t mode,
   input wire logic [ifdd_pkg::PHASE_W-1:0] nco_step,
   input wire logic [ifdd_pkg::DEC_FIELD_W-1:0] dec_count,
   input wire logic sample_valid,
   output logic sample_ready,
   input wire logic signed [SAMPLE_W-1:0] if_sample_in_i,
   input wire logic signed [SAMPLE_W-1:0] if_sample_in_q,
   output logic baseband_sample_strobe,
   input wire logic baseband_ready,
   output logic signed [ACC_W-1:0] baseband_i,
   output logic signed [ACC_W-1:0] baseband_q
);
   import ifdd_pkg::*;
   localparam int PW = SAMPLE_W + NCO_W + 1;
   typedef struct packed {
      logic [PHASE_W-1:0] phase;
      logic [6:0] cnt;
      logic signed [ACC_W-1:0] acc_i;
      logic signed [ACC_W-1:0] acc_q;
      logic dump;
      logic signed [ACC_W-1:0] out_i;
      logic signed [ACC_W-1:0] out_q;
   } ifdd_st_t;
   ifdd_st_t s_q, s_d;
   logic rs1_q, rs_n;
   logic signed [NCO_W-1:0] cosv, sinv;
   logic signed [PW-1:0] mi, mq;
   logic [6:0] n_len;
   logic fifo_ready;
   // Handshake and end-of-window terms shared by the update logic and checks
   logic accept;
   logic last_in;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rs1_q <= 1'b0;
         rs_n <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         rs_n <= rs1_q;
      end
   end

   // Quarter-wave symmetric sine approximation from top phase bits
   function automatic logic signed [NCO_W-1:0] ifdd_sin(input logic [PHASE_W-1:0] ph);
      logic [4:0] idx;
      logic [6:0] mag;
      idx = ph[PHASE_W-2] ? ~ph[PHASE_W-3 -: 5] : ph[PHASE_W-3 -: 5];
      mag = 7'(({2'b00, idx} * 7'h06) - ((7'({2'b00, idx}) * 7'({2'b00, idx})) >> 3));
      ifdd_sin = ph[PHASE_W-1] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
   endfunction

   // Field 0 means 64; clamp to the 2..64 range
   function automatic logic [6:0] ifdd_len(input logic [DEC_FIELD_W-1:0] f);
      ifdd_len = (f < 6'(DEC_MIN)) ? 7'(DEC_MIN) : {1'b0, f};
      if (f == 6'h00) ifdd_len = 7'(DEC_MAX);
   endfunction

   // Tone at minus IF: cos - j sin
   assign cosv = ifdd_sin(s_q.phase + {2'b01, {(PHASE_W-2){1'b0}}});
   assign sinv = -ifdd_sin(s_q.phase);
   assign n_len = ifdd_len(dec_count);
   assign accept = sample_valid && sample_ready;
   // Compare against cnt+1 so a shortened window ends on the next sample
   assign last_in = (s_q.cnt + 7'h01 >= n_len);

   always_comb begin
      if (mode == IFDD_MODE_DIRECT) begin
         // Q input is ignored, so only two products are formed
         mi = PW'(if_sample_in_i * cosv);
         mq = PW'(if_sample_in_i * sinv);
      end else begin
         mi = PW'(if_sample_in_i * cosv) - PW'(if_sample_in_q * sinv);
         mq = PW'(if_sample_in_i * sinv) + PW'(if_sample_in_q * cosv);
      end
   end

   // Input stalls only while a dump is waiting on a full FIFO
   assign sample_ready = !(s_q.dump && !fifo_ready);

   always_comb begin
      s_d = s_q;
      if (s_q.dump && fifo_ready) s_d.dump = 1'b0;
      if (accept) begin
         s_d.phase = s_q.phase + nco_step;
         if (last_in) begin
            s_d.out_i = s_q.acc_i + ACC_W'(mi);
            s_d.out_q = s_q.acc_q + ACC_W'(mq);
            s_d.dump = 1'b1;
            s_d.acc_i = '0;
            s_d.acc_q = '0;
            s_d.cnt = '0;
         end else begin
            s_d.acc_i = s_q.acc_i + ACC_W'(mi);
            s_d.acc_q = s_q.acc_q + ACC_W'(mq);
            s_d.cnt = s_q.cnt + 7'h01;
         end
      end
   end

   always_ff @(posedge mclk or negedge rs_n) begin
      if (!rs_n) s_q <= '0;
      else s_q <= s_d;
   end

   ifdd_fifo #(.WIDTH(2*ACC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(mclk),
      .rst_n(rs_n),
      .in_valid(s_q.dump),
      .in_ready(fifo_ready),
      .in_data({s_q.out_i, s_q.out_q}),
      .out_valid(baseband_sample_strobe),
      .out_ready(baseband_ready),
      .out_data({baseband_i, baseband_q})
   );

   // Checks use the synchronised reset, the same one that clears the state

   // A new window must open from zero, never from the previous sum
   AST_DUMP_CLEARS: assert property (@(posedge mclk) disable iff (!rs_n)
      (s_q.dump && !$past(s_q.dump))
      |-> (s_q.acc_i == '0 && s_q.acc_q == '0))
      else $error("accumulators not cleared at dump");

   // Only a change of the count field may leave the counter past its end
   AST_CNT_RANGE: assert property (@(posedge mclk) disable iff (!rs_n)
      ($stable(dec_count) && $past(s_q.cnt < n_len))
      |-> (s_q.cnt < n_len))
      else $error("decimation count out of range");

   AST_DIRECT_Q_IGNORED: assert property (@(posedge mclk) disable iff (!rs_n)
      (mode == IFDD_MODE_DIRECT)
      |-> (mi == PW'(if_sample_in_i * cosv)))
      else $error("direct mode mixes Q input");

   AST_STALL: assert property (@(posedge mclk) disable iff (!rs_n)
      (s_q.dump && !fifo_ready)
      |-> !sample_ready)
      else $error("input accepted while dump blocked");

   // The clamp must keep the window inside the supported range
   AST_LEN_RANGE: assert property (@(posedge mclk) disable iff (!rs_n)
      (n_len >= 7'(DEC_MIN))
      && (n_len <= 7'(DEC_MAX)))
      else $error("window length outside supported range");

   // The N-th accepted sample closes the window and restarts the count
   AST_DUMP_ON_NTH: assert property (@(posedge mclk) disable iff (!rs_n)
      (accept && last_in)
      |=> (s_q.dump && s_q.cnt == '0))
      else $error("window did not close on its last sample");

   AST_COUNT_ADVANCE: assert property (@(posedge mclk) disable iff (!rs_n)
      (accept && !last_in)
      |=> (s_q.cnt == $past(s_q.cnt) + 7'h01))
      else $error("window count did not advance");

   // Idle cycles must not leak into the integration
   AST_ACC_HOLD: assert property (@(posedge mclk) disable iff (!rs_n)
      !accept
      |=> ($stable(s_q.acc_i) && $stable(s_q.acc_q) && $stable(s_q.cnt)))
      else $error("accumulator moved without an accepted sample");

   // Oscillator phase advances once per accepted sample only
   AST_PHASE_STEP: assert property (@(posedge mclk) disable iff (!rs_n)
      accept
      |=> (s_q.phase == $past(s_q.phase) + $past(nco_step)))
      else $error("oscillator phase step wrong");

   AST_PHASE_HOLD: assert property (@(posedge mclk) disable iff (!rs_n)
      !accept
      |=> $stable(s_q.phase))
      else $error("oscillator phase moved while idle");

   // A finished sum waiting on a full FIFO must not be overwritten
   AST_DUMP_HOLDS: assert property (@(posedge mclk) disable iff (!rs_n)
      (s_q.dump && !fifo_ready)
      |=> (s_q.dump && $stable(s_q.out_i) && $stable(s_q.out_q)))
      else $error("pending sum lost while FIFO full");

   // The sink sees each output until it takes it
   AST_STROBE_HOLDS: assert property (@(posedge mclk) disable iff (!rs_n)
      (baseband_sample_strobe && !baseband_ready)
      |=> (baseband_sample_strobe && $stable(baseband_i) && $stable(baseband_q)))
      else $error("baseband output changed before it was taken");
endmodule // ifdd_top
`default_nettype wire

// ---- tb/ifdd_adc_model.sv ----
// Purpose: Converter model that feeds IF samples to the downconverter
// Assumes: Bench holds en until the sample is taken
// Notes: Idle data is inverted so a stale sample never looks held
`timescale 1ns/1ps
`default_nettype none
module ifdd_adc_model (
   input wire logic en,
   input wire ifdd_pkg::ifdd_mode_t mode,
   input wire logic signed [7:0] val,
   output logic valid,
   output logic signed [7:0] i,
   output logic signed [7:0] q
);
   import ifdd_pkg::*;
   // Low-side IF only, so no Q inversion needs correcting downstream
   assign valid = en;
   assign i = en ? val : ~val;
   assign q = !en ? ~val : ((mode == IFDD_MODE_DIRECT) ? 8'h00 : val);
endmodule // ifdd_adc_model
`default_nettype wire

// ---- tb/if_downconverter_decimator_tb.sv ----
// Purpose: Self-checking bench for the IF downconverter
// Assumes: Oscillator step 0 except one half-turn case, so sine is 0 and cosine is positive at phase 0
// Notes: Values are checked by sign and zero, not by oscillator amplitude
`timescale 1ns/1ps
`default_nettype none
module if_downconverter_decimator_tb;
   import ifdd_pkg::*;
   logic mclk = 0, resetn = 0, en = 0, brdy = 1, srdy, stb, sv;
   ifdd_mode_t mode = IFDD_MODE_QUAD;
   logic [5:0] dec = 6'h02;
   logic [31:0] step = 32'h0;
   logic signed [7:0] val = 8'h05, si, sq;
   logic signed [23:0] bi, bq, li = 0, lq = 0;
   int miscompares = 0, samples_checked = 0, nout = 0, acc = 0, cyc = 0, n0;
   ifdd_adc_model adc (.en(en), .mode(mode), .val(val), .valid(sv), .i(si), .q(sq));
   ifdd_top DUT (.mclk(mclk), .resetn(resetn), .mode(mode), .nco_step(step),
      .dec_count(dec), .sample_valid(sv), .sample_ready(srdy), .if_sample_in_i(si),
      .if_sample_in_q(sq), .baseband_sample_strobe(stb), .baseband_ready(brdy),
      .baseband_i(bi), .baseband_q(bq));
   initial forever #10 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (sv && srdy) acc <= acc + 1;
      if (stb && brdy) begin
         nout <= nout + 1;
         li <= bi;
         lq <= bq;
      end
      if (cyc == 5000) begin
         miscompares++;
         conclude();
      end
   end
   task check(input logic [23:0] s, input logic [23:0] e);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task feed(input int n);
      int t;
      t = acc + n;
      en = 1;
      while (acc < t) begin
         @(posedge mclk);
         #1;
      end
      en = 0;
   endtask
   task settle();
      repeat (8) @(posedge mclk);
      #1;
      n0 = nout;
   endtask
   task t_count(input logic [5:0] d, input int n);
      dec = d;
      settle();
      feed(3 * n);
      repeat (8) @(posedge mclk);
      #1;
      check(nout - n0, 3);
      $display("count test done, N=%0d", n);
   endtask
   task t_modes();
      dec = 6'h02;
      mode = IFDD_MODE_DIRECT;
      feed(2);
      settle();
      check(lq, 0);
      // Half-turn step: cosine flips sign, so two samples cancel
      step = 32'h8000_0000;
      feed(2);
      settle();
      check(li, 0);
      step = 32'h0;
      mode = IFDD_MODE_QUAD;
      feed(2);
      settle();
      check(lq != 0, 1);
      check(li > 0, 1);
      val = 8'h00;
      feed(2);
      settle();
      check(li, 0);
      val = 8'h05;
      $display("mode test done");
   endtask
   task t_stall();
      brdy = 0;
      settle();
      feed(10);
      repeat (3) @(posedge mclk);
      #1;
      check(srdy, 0);
      check(nout - n0, 0);
      brdy = 1;
      repeat (12) @(posedge mclk);
      #1;
      check(nout - n0, 5);
      $display("stall test done");
   endtask
   task conclude();
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      #1 resetn = 1;
      repeat (4) @(posedge mclk);
      #1;
      t_count(6'h02, 2);
      t_count(6'h01, 2);
      t_count(6'h05, 5);
      t_count(6'h00, 64);
      t_modes();
      t_stall();
      conclude();
   end
endmodule // if_downconverter_decimator_tb
`default_nettype wire
